// >>> hw/sspp_defines.vh
// Constants of the synthesizer serial programming port
`ifndef SSPP_DEFINES_VH
`define SSPP_DEFINES_VH

`define SSPP_WORD_BITS 22
`define SSPP_DATA_BITS 18
`define SSPP_ADDR_BITS 4
`define SSPP_NUM_REGS 16

`define SSPP_ADDR_MAIN 4'h0
`define SSPP_ADDR_GAIN 4'h1
`define SSPP_ADDR_POWER 4'h2
`define SSPP_ADDR_RF1_N 4'h3
`define SSPP_ADDR_RF2_N 4'h4
`define SSPP_ADDR_IF_N 4'h5
`define SSPP_ADDR_RF1_R 4'h6
`define SSPP_ADDR_RF2_R 4'h7
`define SSPP_ADDR_IF_R 4'h8

`define SSPP_PWR_RF_BIT 0
`define SSPP_PWR_IF_BIT 1
`define SSPP_IF_OUTPUT_DIVIDER_LSB 10
`define SSPP_IF_OUTPUT_DIVIDER_MSB 11

`define SSPP_TUNE_PERIODS 13
`define SSPP_TUNE_CNT_BITS 4

`define SSPP_LOOP_RF1 0
`define SSPP_LOOP_RF2 1
`define SSPP_LOOP_IF 2
`define SSPP_NUM_LOOPS 3

`define SSPP_REG_RESET 18'h00000

`endif

// >>> hw/sspp_sync.v
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module sspp_sync #(
  parameter WIDTH = 4
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always @(posedge clk) begin
    if (rst) begin
      meta_q <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else if (ce) begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// >>> hw/sspp_top.v
// Serial programming port and loop control of a triple-loop synthesizer
`timescale 1ns/1ps
`include "sspp_defines.vh"

// How it works
// RL1: A word is 22 bits: 18 data bits then a 4-bit register address.
// RL2: While enable is low, each serial clock rising edge shifts in one data bit.
// RL3: Enable rising edge copies the data field into the addressed register.
// RL4: With enable high, serial clock and data are ignored; nothing changes.
// RL5: Surplus leading bits are dropped; only the last 22 bits form the word.
// RL6: Only one RF loop is active: the one whose divider was written last.
// RL7: Self-tuning starts on loop powerup by pin or write, and on new frequency.
// RL8: IF output divider ratio is one of 1, 2, 4 or 8.
// RL9: Writing an RF loop's R or N divider routes that loop to the RF output.
// RL10: Self-tuning lasts 13 phase-detector periods, then the loop takes over.
// RL11: Power bits in register 2 request IF and RF powerup at enable rise.
// RL12: The shift register is 22 bits and shifts only while enable is low.
// RL13: Host lowers enable, shifts exactly 22 bits, then raises enable.
module sspp_top #(
  parameter WORD_BITS = `SSPP_WORD_BITS,
  parameter TUNE_PERIODS = `SSPP_TUNE_PERIODS
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire serial_clk,
  input wire serial_in_line,
  input wire serial_latch_enable_n,
  input wire powerdown_pin_n,
  input wire [`SSPP_NUM_LOOPS-1:0] pd_tick,
  output reg [`SSPP_DATA_BITS-1:0] main_config_q,
  output reg [`SSPP_DATA_BITS-1:0] pd_gain_q,
  output reg [`SSPP_DATA_BITS-1:0] rf1_n_q,
  output reg [`SSPP_DATA_BITS-1:0] rf2_n_q,
  output reg [`SSPP_DATA_BITS-1:0] if_n_q,
  output reg [`SSPP_DATA_BITS-1:0] rf1_r_q,
  output reg [`SSPP_DATA_BITS-1:0] rf2_r_q,
  output reg [`SSPP_DATA_BITS-1:0] if_r_q,
  output reg if_power_on_bit,
  output reg rf_power_on_bit,
  output reg rf2_selected_q,
  output reg [3:0] if_output_divider,
  output reg rf_powered_q,
  output reg if_powered_q,
  output reg [`SSPP_NUM_LOOPS-1:0] tune_active_q,
  output reg [`SSPP_NUM_LOOPS-1:0] loop_control_q
);
  wire [3:0] pins_s;
  wire sclk_s;
  wire serial_in_line_s;
  wire sen_n_s;
  wire powerdown_pin_n_n_s;
  reg sclk_prev_q;
  reg sen_n_prev_q;
  reg [WORD_BITS-1:0] shift_q;
  reg [`SSPP_DATA_BITS-1:0] regs_q [0:`SSPP_NUM_REGS-1];
  reg commit_q;
  reg [`SSPP_ADDR_BITS-1:0] commit_addr_q;
  reg rf_pow_prev_q;
  reg if_pow_prev_q;
  wire sclk_rise;
  wire sen_rise;
  wire [`SSPP_ADDR_BITS-1:0] word_addr;
  wire [`SSPP_DATA_BITS-1:0] word_data;
  wire rf_pow;
  wire if_pow;
  wire [`SSPP_NUM_LOOPS-1:0] tune_start;
  integer i;

  function is_addr;
    input [`SSPP_ADDR_BITS-1:0] a;
    input [`SSPP_ADDR_BITS-1:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  // Pins are asynchronous to clk; serial clock edges are found after syncing
  // Enable is synced inverted so its reset level is idle; no false commit after reset
  sspp_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .async_in({powerdown_pin_n, ~serial_latch_enable_n, serial_in_line, serial_clk}),
    .sync_out(pins_s)
  );

  assign sclk_s = pins_s[0];
  assign serial_in_line_s = pins_s[1];
  assign sen_n_s = ~pins_s[2];
  assign powerdown_pin_n_n_s = pins_s[3];
  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign sen_rise = sen_n_s & ~sen_n_prev_q;
  // Address goes out last, so it sits in the low bits of the shift register
  assign word_addr = shift_q[`SSPP_ADDR_BITS-1:0]; // [RL1]
  assign word_data = shift_q[WORD_BITS-1:`SSPP_ADDR_BITS]; // [RL1]

  // Data and clock share the sync latency, so data is stable at the found edge
  always @(posedge clk) begin
    if (rst) begin
      sclk_prev_q <= 1'b0;
      sen_n_prev_q <= 1'b1;
      shift_q <= {WORD_BITS{1'b0}};
    end else if (ce) begin
      sclk_prev_q <= sclk_s;
      sen_n_prev_q <= sen_n_s;
      if (!sen_n_s && sclk_rise) begin // [RL2] [RL4]
        shift_q <= {shift_q[WORD_BITS-2:0], serial_in_line_s}; // [RL5] [RL12]
      end
    end
  end

  // Commit on enable rise; the register write lands in the same cycle, and the outputs follow one cycle later
  always @(posedge clk) begin
    if (rst) begin
      commit_q <= 1'b0;
      commit_addr_q <= {`SSPP_ADDR_BITS{1'b0}};
      rf2_selected_q <= 1'b0;
      for (i = 0; i < `SSPP_NUM_REGS; i = i + 1) begin
        regs_q[i] <= `SSPP_REG_RESET;
      end
    end else if (ce) begin
      commit_q <= sen_rise;
      if (sen_rise) begin
        regs_q[word_addr] <= word_data; // [RL3]
        commit_addr_q <= word_addr;
        if (is_addr(word_addr, `SSPP_ADDR_RF1_N) || is_addr(word_addr, `SSPP_ADDR_RF1_R)) begin
          rf2_selected_q <= 1'b0; // [RL6] [RL9]
        end else if (is_addr(word_addr, `SSPP_ADDR_RF2_N) || is_addr(word_addr, `SSPP_ADDR_RF2_R)) begin
          rf2_selected_q <= 1'b1; // [RL6] [RL9]
        end
      end
    end
  end

  // Loop power follows the pin and the software power bits together
  assign rf_pow = powerdown_pin_n_n_s & regs_q[`SSPP_ADDR_POWER][`SSPP_PWR_RF_BIT]; // [RL11]
  assign if_pow = powerdown_pin_n_n_s & regs_q[`SSPP_ADDR_POWER][`SSPP_PWR_IF_BIT]; // [RL11]

  // A frequency change is a committed write to that loop's N or R divider
  assign tune_start[`SSPP_LOOP_RF1] = rf_pow & ~rf2_selected_q &
    ((rf_pow & ~rf_pow_prev_q) |
     (commit_q & (is_addr(commit_addr_q, `SSPP_ADDR_RF1_N) | is_addr(commit_addr_q, `SSPP_ADDR_RF1_R))));
  assign tune_start[`SSPP_LOOP_RF2] = rf_pow & rf2_selected_q &
    ((rf_pow & ~rf_pow_prev_q) |
     (commit_q & (is_addr(commit_addr_q, `SSPP_ADDR_RF2_N) | is_addr(commit_addr_q, `SSPP_ADDR_RF2_R))));
  assign tune_start[`SSPP_LOOP_IF] = (if_pow & ~if_pow_prev_q) |
    (if_pow & commit_q & (is_addr(commit_addr_q, `SSPP_ADDR_IF_N) | is_addr(commit_addr_q, `SSPP_ADDR_IF_R)));

  always @(posedge clk) begin
    if (rst) begin
      rf_pow_prev_q <= 1'b0;
      if_pow_prev_q <= 1'b0;
      rf_powered_q <= 1'b0;
      if_powered_q <= 1'b0;
      if_power_on_bit <= 1'b0;
      rf_power_on_bit <= 1'b0;
      if_output_divider <= 4'h1;
      main_config_q <= `SSPP_REG_RESET;
      pd_gain_q <= `SSPP_REG_RESET;
      rf1_n_q <= `SSPP_REG_RESET;
      rf2_n_q <= `SSPP_REG_RESET;
      if_n_q <= `SSPP_REG_RESET;
      rf1_r_q <= `SSPP_REG_RESET;
      rf2_r_q <= `SSPP_REG_RESET;
      if_r_q <= `SSPP_REG_RESET;
    end else if (ce) begin
      rf_pow_prev_q <= rf_pow;
      if_pow_prev_q <= if_pow;
      rf_powered_q <= rf_pow;
      if_powered_q <= if_pow;
      rf_power_on_bit <= regs_q[`SSPP_ADDR_POWER][`SSPP_PWR_RF_BIT];
      if_power_on_bit <= regs_q[`SSPP_ADDR_POWER][`SSPP_PWR_IF_BIT];
      // Two select bits give exactly four ratios as a power of two
      case (regs_q[`SSPP_ADDR_MAIN][`SSPP_IF_OUTPUT_DIVIDER_MSB:`SSPP_IF_OUTPUT_DIVIDER_LSB]) // [RL8]
        2'h0: if_output_divider <= 4'h1;
        2'h1: if_output_divider <= 4'h2;
        2'h2: if_output_divider <= 4'h4;
        default: if_output_divider <= 4'h8;
      endcase
      main_config_q <= regs_q[`SSPP_ADDR_MAIN];
      pd_gain_q <= regs_q[`SSPP_ADDR_GAIN];
      rf1_n_q <= regs_q[`SSPP_ADDR_RF1_N];
      rf2_n_q <= regs_q[`SSPP_ADDR_RF2_N];
      if_n_q <= regs_q[`SSPP_ADDR_IF_N];
      rf1_r_q <= regs_q[`SSPP_ADDR_RF1_R];
      rf2_r_q <= regs_q[`SSPP_ADDR_RF2_R];
      if_r_q <= regs_q[`SSPP_ADDR_IF_R];
    end
  end

  // One tuning timer per loop, counted in phase-detector periods
  genvar g;
  generate
    for (g = 0; g < `SSPP_NUM_LOOPS; g = g + 1) begin : g_tune
      reg [`SSPP_TUNE_CNT_BITS-1:0] cnt_q;
      wire powered;
      if (g == `SSPP_LOOP_RF1) begin : g_p1
        assign powered = rf_pow & ~rf2_selected_q; // [RL6]
      end else if (g == `SSPP_LOOP_RF2) begin : g_p2
        assign powered = rf_pow & rf2_selected_q; // [RL6]
      end else begin : g_p3
        assign powered = if_pow;
      end
      always @(posedge clk) begin
        if (rst) begin
          cnt_q <= {`SSPP_TUNE_CNT_BITS{1'b0}};
          tune_active_q[g] <= 1'b0;
          loop_control_q[g] <= 1'b0;
        end else if (ce) begin
          if (!powered) begin
            cnt_q <= {`SSPP_TUNE_CNT_BITS{1'b0}};
            tune_active_q[g] <= 1'b0;
            loop_control_q[g] <= 1'b0;
          end else if (tune_start[g]) begin
            // A restart mid-tune begins the full period count again
            cnt_q <= {`SSPP_TUNE_CNT_BITS{1'b0}}; // [RL7]
            tune_active_q[g] <= 1'b1; // [RL7]
            loop_control_q[g] <= 1'b0;
          end else if (tune_active_q[g] && pd_tick[g]) begin
            if (cnt_q == TUNE_PERIODS[`SSPP_TUNE_CNT_BITS-1:0] - 4'h1) begin // [RL10]
              tune_active_q[g] <= 1'b0;
              loop_control_q[g] <= 1'b1; // [RL10]
            end else begin
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
      end
    end
  endgenerate
endmodule

// >>> bench/sspp_props.sv
// Checker for the synthesizer serial port
`timescale 1ns/1ps
module sspp_props #(
  parameter TUNE_PERIODS = 13
) (
  input wire clk,
  input wire rst,
  input wire [2:0] pd_tick,
  input wire [17:0] main_config_q,
  input wire [17:0] rf1_n_q,
  input wire [17:0] rf2_n_q,
  input wire [17:0] if_n_q,
  input wire [17:0] rf1_r_q,
  input wire [17:0] rf2_r_q,
  input wire [17:0] if_r_q,
  input wire rf_power_on_bit,
  input wire rf2_selected_q,
  input wire [3:0] if_output_divider,
  input wire rf_powered_q,
  input wire if_powered_q,
  input wire [2:0] tune_active_q,
  input wire [2:0] loop_control_q
);
  reg [7:0] tick_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // A new IF frequency restarts tuning, so the count starts over
  always @(posedge clk) begin
    if (rst || !tune_active_q[2])
      tick_q <= 8'h00;
    else if ($changed(if_n_q) || $changed(if_r_q))
      tick_q <= {7'h00, pd_tick[2]};
    else if (pd_tick[2])
      tick_q <= tick_q + 8'h01;
  end
  rf2_pick_a: assert property (($changed(rf2_n_q) || $changed(rf2_r_q)) |-> rf2_selected_q)
    else $error("rf2 not picked");
  rf1_pick_a: assert property (($changed(rf1_n_q) || $changed(rf1_r_q)) |-> !rf2_selected_q)
    else $error("rf1 not picked");
  if_div_a: assert property ($stable(main_config_q) |-> if_output_divider == (4'h1 << main_config_q[11:10]))
    else $error("if divider wrong");
  rf_off_a: assert property (!rf_power_on_bit [*2] |-> !rf_powered_q)
    else $error("rf powered without bit");
  tune_go_a: assert property ($rose(if_powered_q) |-> ##[0:2] tune_active_q[2])
    else $error("if tuning not started");
  tune_end_a: assert property ($rose(loop_control_q[2]) |-> $fell(tune_active_q[2]) && $past(pd_tick[2]))
    else $error("handover off tick");
  tune_len_a: assert property ($rose(loop_control_q[2]) |-> tick_q == TUNE_PERIODS)
    else $error("tuning length wrong");
  tune_excl_a: assert property ((tune_active_q & loop_control_q) == 3'h0)
    else $error("tuning overlaps control");
endmodule
bind sspp_top sspp_props #(.TUNE_PERIODS(TUNE_PERIODS)) i_sspp_props (.*);

// >>> bench/sspp_host.sv
// Host model shifting words into the port
`timescale 1ns/1ps
module sspp_host (
  output logic serial_clk,
  output logic serial_in_line,
  output logic serial_latch_enable_n
);
  initial begin
    serial_clk = 1'b0;
    serial_in_line = 1'b0;
    serial_latch_enable_n = 1'b1;
  end
  // Low n bits of w go out first bit highest; en low keeps the enable high
  task automatic send(input logic [31:0] w, input int n, input bit en);
    serial_latch_enable_n = !en;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in_line = w[i];
      #62.5 serial_clk = 1'b1;
      #62.5 serial_clk = 1'b0;
    end
    // Flip the released line so a stale bit never passes for data
    serial_in_line = !serial_in_line;
    #62.5 serial_latch_enable_n = 1'b1;
    #200;
  endtask
endmodule

// >>> bench/tb_sspp_top.sv
// Self-checking bench for the serial programming port
`timescale 1ns/1ps
module tb_sspp_top;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, powerdown_pin_n = 1'b1, sel = 1'b0, sel_d = 1'b0;
  logic [2:0] pd_tick = 3'h0;
  wire serial_clk, serial_in_line, serial_latch_enable_n;
  wire [17:0] main_config_q, pd_gain_q, rf1_n_q, rf2_n_q, if_n_q, rf1_r_q, rf2_r_q, if_r_q;
  wire if_power_on_bit, rf_power_on_bit, rf2_selected_q, rf_powered_q, if_powered_q;
  wire [3:0] if_output_divider;
  wire [2:0] tune_active_q, loop_control_q;
  wire [150:0] obs = {main_config_q, pd_gain_q, rf1_n_q, rf2_n_q, if_n_q, rf1_r_q, rf2_r_q, if_r_q,
    if_power_on_bit, rf_power_on_bit, sel_d, if_output_divider};
  logic [150:0] q[$], last_v, prev_obs;
  logic [17:0] m[0:15];
  int miscompares = 0, compares = 0;
  sspp_top i_sspp_top (.*);
  sspp_host i_sspp_host (.*);
  initial forever #4 clk = ~clk;
  // Selection flips one cycle before the registers, so align it for the monitor
  always @(posedge clk) sel_d <= rf2_selected_q;
  // Ticks never come back to back, as a real update period is long
  always @(posedge clk) pd_tick <= (pd_tick == 3'h0 && $urandom % 16 == 0) ? 3'h7 : 3'h0;
  function automatic logic [150:0] model();
    return {m[0], m[1], m[3], m[4], m[5], m[6], m[7], m[8], m[2][1:0], sel, 4'h1 << m[0][11:10]};
  endfunction
  task automatic check(input logic [150:0] seen, input logic [150:0] want, input string nm);
    compares++;
    if (seen !== want) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [17:0] d, input int extra);
    logic [31:0] w;
    w = {10'($urandom), d, a};
    m[a] = d;
    if (a == 4'h3 || a == 4'h6) sel = 1'b0;
    if (a == 4'h4 || a == 4'h7) sel = 1'b1;
    if (model() !== last_v) q.push_back(model());
    last_v = model();
    i_sspp_host.send(w, 22 + extra, 1'b1);
  endtask
  task automatic drain(input string nm);
    for (int i = 0; i < 200 && q.size() != 0; i++) @(posedge clk);
    check(151'(q.size()), 151'(0), nm);
    $display("test %s done", nm);
  endtask
  task automatic tuned(input string nm);
    for (int i = 0; i < 2000 && loop_control_q !== {1'b1, sel, !sel}; i++) @(posedge clk);
    check(151'(loop_control_q), 151'({1'b1, sel, !sel}), nm);
    $display("test %s done", nm);
  endtask
  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    if (!rst && obs !== prev_obs && q.size() == 0) check(obs, prev_obs, "quiet");
    else if (!rst && obs !== prev_obs) check(obs, q.pop_front(), "regs");
    prev_obs <= obs;
  end
  initial begin
    void'($urandom(32'h8731));
    foreach (m[i]) m[i] = 18'h0;
    last_v = model();
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    check(obs, last_v, "reset");
    $display("test reset done");
    for (int a = 0; a < 16; a++) wr(4'(a), 18'($urandom), 0);
    drain("addr");
    for (int k = 1; k <= 10; k++) wr(4'(k % 9), 18'($urandom), k);
    drain("surplus");
    i_sspp_host.send($urandom, 22, 1'b0);
    drain("idle");
    for (int k = 0; k < 4; k++) wr(4'h0, {6'($urandom), 2'(k), 10'($urandom)}, 0);
    drain("if_output_divider");
    wr(4'h2, 18'h00003, 0);
    drain("power");
    tuned("soft");
    @(posedge clk) begin
      ce <= 1'b0;
      powerdown_pin_n <= 1'b0;
    end
    repeat (10) @(posedge clk);
    check(151'({rf_powered_q, if_powered_q}), 151'(2'h3), "freeze");
    $display("test freeze done");
    ce <= 1'b1;
    repeat (20) @(posedge clk);
    check(151'({rf_powered_q, if_powered_q, loop_control_q, tune_active_q}), 151'(0), "pin");
    $display("test pin done");
    powerdown_pin_n <= 1'b1;
    tuned("repower");
    finish_test();
  end
  // Some thirty words of 3 us each plus two tuning waits fit well inside this span
  initial begin
    #600us;
    miscompares++;
    finish_test();
  end
endmodule
